// ### logic/alpc_clkdiv.sv
/*
  conversion clock tick generator: source select and power-of-two divider.
  assumes alt and async ticks are already synchronised one-cycle pulses.
*/
`timescale 1ns/10ps
`include "alpc_defs.svh"
module alpc_clkdiv
  import alpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] src,
  input wire logic [1:0] div,
  input wire logic alt_tick,
  input wire logic async_tick,
  output logic tick
);
  logic half_q, half_d;
  logic [2:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic base;
  logic [2:0] limit;

  always_comb begin
    half_d = ~half_q;
    case (src)
      `ALPC_CLK_BUS: base = 1'b1;
      `ALPC_CLK_BUS_HALF: base = half_q;
      `ALPC_CLK_ALT: base = alt_tick;
      `ALPC_CLK_ASYNC: base = async_tick;
      default: base = 1'b0;
    endcase
    limit = 3'((4'h1 << div) - 4'h1);
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = 3'h0;
    end else if (base) begin
      if (cnt_q == limit) begin
        cnt_d = 3'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_q <= 1'b0;
      cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      half_q <= half_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : alpc_clkdiv

// ### logic/alpc_defs.svh
/*
  register offsets, field positions, reset values and timing counts for the
  converter control block. assumes byte-wide registers on a plain port.
*/
`ifndef ALPC_DEFS_SVH
`define ALPC_DEFS_SVH
`define ALPC_OFS_CFG 4'h0
`define ALPC_OFS_SC2 4'h1
`define ALPC_OFS_SC1 4'h2
`define ALPC_OFS_RH 4'h3
`define ALPC_OFS_RL 4'h4
`define ALPC_OFS_CVH 4'h5
`define ALPC_OFS_CVL 4'h6
`define ALPC_OFS_PC1 4'h7
`define ALPC_OFS_PC2 4'h8
`define ALPC_CFG_LP_BIT 7
`define ALPC_CFG_DIV_HI 6
`define ALPC_CFG_DIV_LO 5
`define ALPC_CFG_LSMP_BIT 4
`define ALPC_CFG_MODE_HI 3
`define ALPC_CFG_MODE_LO 2
`define ALPC_CFG_CLK_HI 1
`define ALPC_CFG_CLK_LO 0
`define ALPC_SC2_ACT_BIT 7
`define ALPC_SC2_TRG_BIT 6
`define ALPC_SC2_CFE_BIT 5
`define ALPC_SC2_CGT_BIT 4
`define ALPC_SC1_DONE_BIT 7
`define ALPC_SC1_IEN_BIT 6
`define ALPC_SC1_CONT_BIT 5
`define ALPC_SC1_CH_HI 4
`define ALPC_SC1_CH_LO 0
`define ALPC_MODE_10BIT 2'h2
`define ALPC_CLK_BUS 2'h0
`define ALPC_CLK_BUS_HALF 2'h1
`define ALPC_CLK_ALT 2'h2
`define ALPC_CLK_ASYNC 2'h3
`define ALPC_CH_DISABLED 5'h1f
`define ALPC_RST_CFG 8'h00
`define ALPC_RST_SC2 8'h00
`define ALPC_RST_SC1 8'h1f
`define ALPC_RST_CV 8'h00
`define ALPC_RST_PC 8'h00
`define ALPC_RST_RES 10'h000
`define ALPC_FULL_10 10'h3ff
`define ALPC_FULL_8 10'h0ff
`define ALPC_STEPS_10 4'h9
`define ALPC_STEPS_8 4'h7
`define ALPC_SAMPLE_SHORT_TENTHS 35
`define ALPC_SAMPLE_LONG_TENTHS 235
`define ALPC_SAMPLE_SHORT_TICKS ((`ALPC_SAMPLE_SHORT_TENTHS + 9) / 10)
`define ALPC_SAMPLE_LONG_TICKS ((`ALPC_SAMPLE_LONG_TENTHS + 9) / 10)
`endif

// ### logic/alpc_pkg.sv
/*
  types and shared decoding for the converter control block.
  assumes the defs header supplies all numeric constants.
*/
`include "alpc_defs.svh"
package alpc_pkg;
  typedef enum logic [1:0] {
    sar_idle = 2'b00,
    sar_sample = 2'b01,
    sar_convert = 2'b10
  } alpc_sar_state_type;

  function automatic logic alpc_ten_bit(input logic [1:0] mode);
    alpc_ten_bit = (mode == `ALPC_MODE_10BIT);
  endfunction : alpc_ten_bit
endpackage : alpc_pkg

// ### logic/alpc_sar.sv
/*
  successive approximation sequencer: sample window then one bit per tick.
  assumes cmp_above is synchronised and means input >= trial code.
*/
`timescale 1ns/10ps
`include "alpc_defs.svh"
module alpc_sar
  import alpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input wire logic abort,
  input wire logic ten_bit,
  input wire logic long_sample,
  input wire logic cmp_above,
  output logic busy,
  output logic sample_en,
  output logic [9:0] trial_code,
  output logic done,
  output logic [9:0] result
);
  alpc_sar_state_type st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] code_q, code_d, res_q, res_d;
  logic done_q, done_d;
  logic [1:0] wait_q, wait_d;
  logic pend_q, pend_d, step;
  logic [4:0] win;
  logic [9:0] kept;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    code_d = code_q;
    res_d = res_q;
    done_d = 1'b0;
    wait_d = (wait_q == 2'h0) ? 2'h0 : wait_q - 2'h1;
    pend_d = 1'b0;
    // the comparator arrives through two sync flops, so each trial settles for
    // three clocks; early ticks are held, which stretches fast conversions
    step = (tick | pend_q) & (wait_q == 2'h0);
    // least time rounded up to whole conversion-clock cycles
    win = long_sample ? 5'(`ALPC_SAMPLE_LONG_TICKS) : 5'(`ALPC_SAMPLE_SHORT_TICKS);
    kept = cmp_above ? code_q : (code_q & ~(10'h001 << bit_q));
    case (st_q)
      sar_idle: ;
      sar_sample: begin
        if (tick) begin
          if (cnt_q == win - 5'h01) begin
            st_d = sar_convert;
            bit_d = ten_bit ? `ALPC_STEPS_10 : `ALPC_STEPS_8;
            code_d = 10'h001 << bit_d;
            wait_d = 2'h2;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      sar_convert: begin
        if (step) begin
          if (bit_q == 4'h0) begin
            st_d = sar_idle;
            res_d = kept;
            done_d = 1'b1;
          end else begin
            bit_d = bit_q - 4'h1;
            code_d = kept | (10'h001 << bit_d);
            wait_d = 2'h2;
          end
        end else begin
          pend_d = pend_q | tick;
        end
      end
      default: st_d = sar_idle;
    endcase
    if (start) begin
      st_d = sar_sample;
      cnt_d = 5'h00;
      code_d = 10'h000;
      done_d = 1'b0;
    end else if (abort) begin
      st_d = sar_idle;
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= sar_idle;
      cnt_q <= 5'h00;
      bit_q <= 4'h0;
      code_q <= 10'h000;
      res_q <= 10'h000;
      done_q <= 1'b0;
      wait_q <= 2'h0;
      pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      code_q <= code_d;
      res_q <= res_d;
      done_q <= done_d;
      wait_q <= wait_d;
      pend_q <= pend_d;
    end
  end

  assign busy = (st_q != sar_idle);
  assign sample_en = (st_q == sar_sample);
  assign trial_code = code_q;
  assign done = done_q;
  assign result = res_q;
endmodule : alpc_sar

// ### logic/alpc_top.sv
/*
  converter control block: register file, trigger and compare logic, result
  blocking and low-power stop handling around the sar sequencer.
  assumes the power controller drives stop3_active/stop12_active on clk_sys,
  and all pin and analog inputs are asynchronous.
*/
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "alpc_defs.svh"
// Summary of operation
// - stop3 entry without async clock aborts conversion and idles converter.
// - stop3 entry and exit never alter result registers.
// - after such a stop3 exit, converter idles until a new trigger.
// - with async clock selected, conversions keep running through stop3.
// - in stop3 with async clock, hardware trigger and continuous mode start conversions.
// - completion sets done flag unless compare is enabled and missed; interrupt raised when interrupt enable is 1.
// - stop1/stop2 disable converter and return all registers to reset values.
// - configuration fields: low power, divider, long sample, resolution, clock source.
// - divider 00 passes clock undivided; source 00 selects bus clock.
// - control two: active flag, trigger select, compare enable, compare greater.
// - control two bits 3:2 read zero; bits 1:0 written zero.
// - control one: done flag, interrupt enable, continuous, channel select.
// - channel select value is the channel number.
// - high byte read first; in 10-bit mode pair protected until low byte read.
// - compare value registers give the compare threshold.
// - pin-control bits disable digital control; conversion proceeds either way.
// - result saturates at full scale above high reference, zero below low.
// - sample window 4 or 24 conversion clocks (3.5 or 23.5 rounded up) by long sample select.
// - control one write aborts; in software trigger mode it restarts unless channel is all ones.
// - blocked 10-bit result is discarded and does not set the done flag; an already set flag stays set.
module alpc_top
  import alpc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic stop3_active,
  input wire logic stop12_active,
  input wire logic hw_trigger_pin,
  input wire logic alt_clock_pin,
  input wire logic async_conv_clock,
  input wire logic cmp_above_pin,
  input wire logic ref_high_pin,
  input wire logic ref_low_pin,
  output logic conv_irq,
  output logic sample_enable,
  output logic [9:0] trial_code,
  output logic [4:0] channel_select,
  output logic [15:0] pin_digital_disable,
  output logic low_power_select,
  output logic async_clock_enable
);
  localparam int NSYNC = 6;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [NSYNC-1:0] sync1_q, sync2_q, sync3_q;
  logic [NSYNC-1:0] pins;
  logic [7:0] cfg_q, cfg_d, sc2_q, sc2_d, sc1_q, sc1_d;
  logic [7:0] cvh_q, cvh_d, cvl_q, cvl_d, pc1_q, pc1_d, pc2_q, pc2_d;
  logic [9:0] res_q, res_d;
  logic lock_q, lock_d, stop3_q, stop3_d;
  logic [7:0] rdata_q, rdata_d;
  logic ten, async_sel, inhibit, ch_off, stop3_enter;
  logic wr_cfg, wr_sc2, wr_sc1, wr_cvh, wr_cvl, rd_rh, rd_rl;
  logic start_hw, restart, start_any, abort_any;
  logic done_set, cond, pass;
  logic [9:0] raw, cv, diff;
  logic hw_rise, alt_tick, async_tick;
  logic conv_tick, sar_busy, sar_done;
  logic [9:0] sar_result;

  // every pin passes two flops before any logic looks at it
  assign pins = {ref_low_pin, ref_high_pin, cmp_above_pin, async_conv_clock,
                 alt_clock_pin, hw_trigger_pin};
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
          sync3_q[i] <= 1'b0;
        end else begin
          sync1_q[i] <= pins[i];
          sync2_q[i] <= sync1_q[i];
          sync3_q[i] <= sync2_q[i];
        end
      end
    end
  endgenerate

  assign hw_rise = sync2_q[0] & ~sync3_q[0];
  assign alt_tick = sync2_q[1] & ~sync3_q[1];
  // the async clock is only usable well below clk_sys/4 after sampling
  assign async_tick = sync2_q[2] & ~sync3_q[2];

  assign ten = alpc_ten_bit(cfg_q[`ALPC_CFG_MODE_HI:`ALPC_CFG_MODE_LO]);
  assign async_sel = (cfg_q[`ALPC_CFG_CLK_HI:`ALPC_CFG_CLK_LO] == `ALPC_CLK_ASYNC);
  // without the async clock the conversion clock is gone in stop3
  assign inhibit = (stop3_active & ~async_sel) | stop12_active;
  assign stop3_enter = stop3_active & ~stop3_q;
  assign ch_off = (sc1_q[`ALPC_SC1_CH_HI:`ALPC_SC1_CH_LO] == `ALPC_CH_DISABLED);

  assign wr_cfg = bus_wr & hit(bus_addr, `ALPC_OFS_CFG);
  assign wr_sc2 = bus_wr & hit(bus_addr, `ALPC_OFS_SC2);
  assign wr_sc1 = bus_wr & hit(bus_addr, `ALPC_OFS_SC1);
  assign wr_cvh = bus_wr & hit(bus_addr, `ALPC_OFS_CVH);
  assign wr_cvl = bus_wr & hit(bus_addr, `ALPC_OFS_CVL);
  assign rd_rh = bus_rd & hit(bus_addr, `ALPC_OFS_RH);
  assign rd_rl = bus_rd & hit(bus_addr, `ALPC_OFS_RL);

  // result of the finished conversion, saturated at the references
  always_comb begin
    raw = sar_result;
    if (sync2_q[4]) begin
      raw = ten ? `ALPC_FULL_10 : `ALPC_FULL_8;
    end else if (sync2_q[5]) begin
      raw = 10'h000;
    end
    cv = ten ? {cvh_q[1:0], cvl_q} : {2'h0, cvl_q};
    diff = raw - cv;
    cond = sc2_q[`ALPC_SC2_CGT_BIT] ? (raw >= cv) : (raw < cv);
    pass = ~sc2_q[`ALPC_SC2_CFE_BIT] | cond;
  end

  always_comb begin
    start_hw = sc2_q[`ALPC_SC2_TRG_BIT] & hw_rise & ~ch_off & ~inhibit;
    restart = 1'b0;
    done_set = 1'b0;
    if (sar_done && !(stop3_enter && !async_sel)) begin
      if (lock_q) begin
        // blocked pair: result dropped, another conversion unless single compare miss
        restart = ~(~sc1_q[`ALPC_SC1_CONT_BIT] & sc2_q[`ALPC_SC2_CFE_BIT] & ~cond);
      end else begin
        done_set = pass;
        restart = sc1_q[`ALPC_SC1_CONT_BIT];
      end
    end
    // a config, control or compare register write in the same cycle wins over an automatic restart
    restart = restart & ~ch_off & ~inhibit & ~abort_any;
  end

  // a write to control one triggers only in software trigger mode
  logic sw_go;
  assign sw_go = wr_sc1 & ~sc2_q[`ALPC_SC2_TRG_BIT] &
                 (bus_wdata[`ALPC_SC1_CH_HI:`ALPC_SC1_CH_LO] != `ALPC_CH_DISABLED) & ~inhibit;
  assign start_any = (sw_go | start_hw | restart) & ~stop12_active;
  assign abort_any = wr_cfg | wr_sc2 | wr_sc1 | wr_cvh | wr_cvl |
                     (stop3_enter & ~async_sel) | stop12_active;

  always_comb begin
    cfg_d = cfg_q;
    sc2_d = sc2_q;
    sc1_d = sc1_q;
    cvh_d = cvh_q;
    cvl_d = cvl_q;
    pc1_d = pc1_q;
    pc2_d = pc2_q;
    res_d = res_q;
    lock_d = lock_q;
    stop3_d = stop3_active;
    rdata_d = 8'h00;
    if (wr_cfg) begin
      cfg_d = bus_wdata;
    end
    if (wr_sc2) begin
      // active flag is read-only; low nibble never stored
      sc2_d = {1'b0, bus_wdata[6:4], 4'h0};
    end
    if (wr_cvh) begin
      cvh_d = bus_wdata;
    end
    if (wr_cvl) begin
      cvl_d = bus_wdata;
    end
    if (bus_wr & hit(bus_addr, `ALPC_OFS_PC1)) begin
      pc1_d = bus_wdata;
    end
    if (bus_wr & hit(bus_addr, `ALPC_OFS_PC2)) begin
      pc2_d = bus_wdata;
    end
    // mode changes and low-byte reads clear the done flag
    if (wr_cfg | wr_sc2 | wr_cvh | wr_cvl | rd_rl) begin
      sc1_d[`ALPC_SC1_DONE_BIT] = 1'b0;
    end
    if (wr_sc1) begin
      sc1_d = {1'b0, bus_wdata[6:0]};
    end
    if (rd_rh & ten) begin
      lock_d = 1'b1;
    end
    if (rd_rl) begin
      lock_d = 1'b0;
    end
    // transfer after clears so a completion in a clearing cycle is kept
    if (done_set) begin
      res_d = sc2_q[`ALPC_SC2_CFE_BIT] ? diff : raw;
      sc1_d[`ALPC_SC1_DONE_BIT] = 1'b1;
    end
    if (bus_rd) begin
      case (bus_addr)
        `ALPC_OFS_CFG: rdata_d = cfg_q;
        `ALPC_OFS_SC2: rdata_d = {sar_busy, sc2_q[6:4], 4'h0};
        `ALPC_OFS_SC1: rdata_d = sc1_q;
        `ALPC_OFS_RH: rdata_d = ten ? {6'h00, res_q[9:8]} : 8'h00;
        `ALPC_OFS_RL: rdata_d = res_q[7:0];
        `ALPC_OFS_CVH: rdata_d = cvh_q;
        `ALPC_OFS_CVL: rdata_d = cvl_q;
        `ALPC_OFS_PC1: rdata_d = pc1_q;
        `ALPC_OFS_PC2: rdata_d = pc2_q;
        default: rdata_d = 8'h00;
      endcase
    end
    if (stop12_active) begin
      cfg_d = `ALPC_RST_CFG;
      sc2_d = `ALPC_RST_SC2;
      sc1_d = `ALPC_RST_SC1;
      cvh_d = `ALPC_RST_CV;
      cvl_d = `ALPC_RST_CV;
      pc1_d = `ALPC_RST_PC;
      pc2_d = `ALPC_RST_PC;
      res_d = `ALPC_RST_RES;
      lock_d = 1'b0;
    end
  end

  // byte-wide registers, one bus cycle per access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_q <= `ALPC_RST_CFG;
      sc2_q <= `ALPC_RST_SC2;
      sc1_q <= `ALPC_RST_SC1;
      cvh_q <= `ALPC_RST_CV;
      cvl_q <= `ALPC_RST_CV;
      pc1_q <= `ALPC_RST_PC;
      pc2_q <= `ALPC_RST_PC;
      res_q <= `ALPC_RST_RES;
      lock_q <= 1'b0;
      stop3_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      sc2_q <= sc2_d;
      sc1_q <= sc1_d;
      cvh_q <= cvh_d;
      cvl_q <= cvl_d;
      pc1_q <= pc1_d;
      pc2_q <= pc2_d;
      res_q <= res_d;
      lock_q <= lock_d;
      stop3_q <= stop3_d;
      rdata_q <= rdata_d;
    end
  end

  alpc_clkdiv u_clkdiv (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(sar_busy | start_any),
    .src(cfg_q[`ALPC_CFG_CLK_HI:`ALPC_CFG_CLK_LO]),
    .div(cfg_q[`ALPC_CFG_DIV_HI:`ALPC_CFG_DIV_LO]),
    .alt_tick(alt_tick),
    .async_tick(async_tick),
    .tick(conv_tick)
  );

  alpc_sar u_sar (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(conv_tick),
    .start(start_any),
    .abort(abort_any),
    .ten_bit(ten),
    .long_sample(cfg_q[`ALPC_CFG_LSMP_BIT]),
    .cmp_above(sync2_q[3]),
    .busy(sar_busy),
    .sample_en(sample_enable),
    .trial_code(trial_code),
    .done(sar_done),
    .result(sar_result)
  );

  assign bus_rdata = rdata_q;
  assign conv_irq = sc1_q[`ALPC_SC1_DONE_BIT] & sc1_q[`ALPC_SC1_IEN_BIT];
  assign channel_select = sc1_q[`ALPC_SC1_CH_HI:`ALPC_SC1_CH_LO];
  // pin-control only gates digital buffers; conversion never looks at it
  assign pin_digital_disable = {pc2_q, pc1_q};
  assign low_power_select = cfg_q[`ALPC_CFG_LP_BIT];
  assign async_clock_enable = async_sel & sar_busy;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_stop3_abort;
    stop3_enter && !async_sel |=> !sar_busy;
  endproperty
  a_stop3_abort: assert property (p_stop3_abort) else $error("stop3 did not abort");

  property p_stop3_result;
    (stop3_enter || $fell(stop3_active)) && !async_sel && !stop12_active |=> $stable(res_q);
  endproperty
  a_stop3_result: assert property (p_stop3_result) else $error("stop3 changed result");

  property p_stop3_idle;
    $fell(stop3_active) && !sar_busy && !start_any |=> !sar_busy;
  endproperty
  a_stop3_idle: assert property (p_stop3_idle) else $error("started without trigger");

  property p_async_run;
    stop3_active && async_sel && sar_busy && !abort_any |=> sar_busy || sar_done;
  endproperty
  a_async_run: assert property (p_async_run) else $error("conversion lost in stop3");

  property p_hw_start;
    stop3_active && async_sel && start_hw && !stop12_active |=> sar_busy;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hw trigger ignored");

  property p_done_irq;
    sar_done && !lock_q && !sc2_q[`ALPC_SC2_CFE_BIT] && !stop12_active && !wr_sc1
      && !(stop3_enter && !async_sel)
      |=> sc1_q[`ALPC_SC1_DONE_BIT] && (conv_irq == sc1_q[`ALPC_SC1_IEN_BIT]);
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done flag or irq wrong");

  property p_stop12;
    stop12_active |=> cfg_q == `ALPC_RST_CFG && sc1_q == `ALPC_RST_SC1 && res_q == 10'h000
      && !sar_busy;
  endproperty
  a_stop12: assert property (p_stop12) else $error("stop1/2 did not reset");

  property p_sc2_read;
    bus_rd && bus_addr == `ALPC_OFS_SC2 |=> bus_rdata[3:0] == 4'h0
      && bus_rdata[7] == $past(sar_busy);
  endproperty
  a_sc2_read: assert property (p_sc2_read) else $error("control two read wrong");

  property p_sw_start;
    sw_go && !stop12_active |=> sar_busy ##1 sample_enable;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("write did not restart");

  property p_block;
    lock_q && sar_done && !stop12_active |=> $stable(res_q)
      && !$rose(sc1_q[`ALPC_SC1_DONE_BIT]);
  endproperty
  a_block: assert property (p_block) else $error("blocked result transferred");

  c_done: cover property (sar_done && done_set);
  c_blocked: cover property (sar_done && lock_q);
  c_stop3_async: cover property (stop3_active && async_sel && sar_done);
  c_compare_miss: cover property (sar_done && sc2_q[`ALPC_SC2_CFE_BIT] && !cond);
endmodule : alpc_top

// ### verification/alpc_analog_model.sv
/*
  analog front end seen by the converter: comparator and reference detectors.
  assumes the bench sets the input level and whether it sits at a reference rail.
*/
`timescale 1ns/10ps
module alpc_analog_model (
  input wire logic [9:0] trial_code,
  input wire logic [9:0] level,
  input wire logic at_high,
  input wire logic at_low,
  output logic cmp_above_pin,
  output logic ref_high_pin,
  output logic ref_low_pin
);
  // ideal comparator, no offset, so the result equals the level exactly
  assign cmp_above_pin = (level >= trial_code);
  assign ref_high_pin = at_high;
  assign ref_low_pin = at_low;
endmodule : alpc_analog_model

// ### verification/alpc_top_tb.sv
/*
  self-checking bench for the converter control block: register port tasks,
  conversions, stop modes and result locking.
  assumes the analog model stands in for the comparator and references.
*/
`timescale 1ns/10ps
module alpc_top_tb;
  logic clk_sys = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic stop3 = 1'b0, stop12 = 1'b0, trig = 1'b0, aclk = 1'b0, arun = 1'b0;
  logic hi = 1'b0, lo = 1'b0, cmp, rh, rl, conv_irq, sample_enable, lp, ace;
  logic [9:0] ain = 10'h000, trial_code;
  logic [4:0] channel_select;
  logic [15:0] pin_dis;
  int failures = 0, checked = 0;

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // async clock at an eighth of the system rate, still within its frames
  always #200 aclk = arun ? ~aclk : 1'b0;

  alpc_top alpc_top_i (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .stop3_active(stop3), .stop12_active(stop12), .hw_trigger_pin(trig),
    .alt_clock_pin(1'b0), .async_conv_clock(aclk), .cmp_above_pin(cmp),
    .ref_high_pin(rh), .ref_low_pin(rl), .conv_irq(conv_irq),
    .sample_enable(sample_enable), .trial_code(trial_code),
    .channel_select(channel_select), .pin_digital_disable(pin_dis),
    .low_power_select(lp), .async_clock_enable(ace));
  alpc_analog_model alpc_analog_model_i (.trial_code(trial_code), .level(ain),
    .at_high(hi), .at_low(lo), .cmp_above_pin(cmp), .ref_high_pin(rh),
    .ref_low_pin(rl));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1;
    chk({8'h00, bus_rdata}, {8'h00, e});
  endtask : rd
  // e=0 waits the whole span, so a late interrupt is still caught
  task wait_irq(input int n, input logic e);
    int i;
    logic seen;
    seen = 1'b0;
    i = 0;
    while (i < n && !(seen === 1'b1 && e === 1'b1)) begin
      @(posedge clk_sys);
      #1;
      if (conv_irq === 1'b1) seen = 1'b1;
      i++;
    end
    chk({15'h0, seen}, {15'h0, e});
  endtask : wait_irq
  task win(input int e);
    int k;
    k = 0;
    repeat (300) begin
      if (sample_enable === 1'b1) k++;
      @(posedge clk_sys);
      #1;
    end
    chk(k[15:0], e[15:0]);
  endtask : win
  task stop_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #1000000;
    failures++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h1f);
    rd(4'h9, 8'h00);
    chk({11'h0, channel_select}, 16'h001f);
    $display("test reset done");
    wr(4'h0, 8'h98);
    rd(4'h0, 8'h98);
    chk({15'h0, lp}, 16'h0001);
    wr(4'h1, 8'h4c);
    rd(4'h1, 8'h40);
    wr(4'h1, 8'h00);
    wr(4'h7, 8'h02);
    wr(4'h8, 8'h80);
    chk(pin_dis, 16'h8002);
    $display("test config done");
    wr(4'h0, 8'h08);
    ain <= 10'h2a5;
    wr(4'h2, 8'h41);
    win(4);
    chk({15'h0, conv_irq}, 16'h0001);
    rd(4'h2, 8'hc1);
    chk({11'h0, channel_select}, 16'h0001);
    rd(4'h3, 8'h02);
    rd(4'h4, 8'ha5);
    rd(4'h2, 8'h41);
    wr(4'h0, 8'h18);
    wr(4'h2, 8'h41);
    win(24);
    wr(4'h0, 8'h28);
    wr(4'h2, 8'h41);
    win(8);
    $display("test single done");
    hi <= 1'b1;
    wr(4'h0, 8'h08);
    wr(4'h2, 8'h41);
    wait_irq(100, 1'b1);
    rd(4'h3, 8'h03);
    rd(4'h4, 8'hff);
    hi <= 1'b0;
    lo <= 1'b1;
    wr(4'h2, 8'h41);
    wait_irq(100, 1'b1);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    lo <= 1'b0;
    hi <= 1'b1;
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h41);
    wait_irq(100, 1'b1);
    rd(4'h4, 8'hff);
    hi <= 1'b0;
    $display("test saturate done");
    wr(4'h0, 8'h08);
    ain <= 10'h155;
    wr(4'h2, 8'h41);
    repeat (3) @(posedge clk_sys);
    stop3 <= 1'b1;
    wait_irq(100, 1'b0);
    chk({15'h0, sample_enable}, 16'h0000);
    stop3 <= 1'b0;
    wait_irq(100, 1'b0);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'hff);
    wr(4'h2, 8'h41);
    wait_irq(100, 1'b1);
    rd(4'h3, 8'h01);
    rd(4'h4, 8'h55);
    $display("test stop3 bus clock done");
    wr(4'h0, 8'h0b);
    wr(4'h1, 8'h40);
    wr(4'h2, 8'h41);
    arun <= 1'b1;
    stop3 <= 1'b1;
    repeat (5) @(posedge clk_sys);
    trig <= 1'b1;
    repeat (3) @(posedge clk_sys);
    trig <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({15'h0, ace}, 16'h0001);
    wait_irq(1000, 1'b1);
    stop3 <= 1'b0;
    arun <= 1'b0;
    rd(4'h3, 8'h01);
    rd(4'h4, 8'h55);
    $display("test stop3 async done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h08);
    ain <= 10'h111;
    wr(4'h2, 8'h61);
    wait_irq(200, 1'b1);
    rd(4'h3, 8'h01);
    ain <= 10'h333;
    repeat (150) @(posedge clk_sys);
    rd(4'h4, 8'h11);
    wr(4'h2, 8'h5f);
    win(0);
    $display("test lock done");
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h00);
    wr(4'h1, 8'h30);
    ain <= 10'h180;
    wr(4'h2, 8'h41);
    wait_irq(200, 1'b1);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h80);
    $display("test compare done");
    @(posedge clk_sys);
    stop12 <= 1'b1;
    @(posedge clk_sys);
    stop12 <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h1f);
    rd(4'h5, 8'h00);
    rd(4'h7, 8'h00);
    $display("test stop12 done");
    stop_test();
  end
endmodule : alpc_top_tb
